/* File: design/i2csw_ctrl.sv */
// Control logic of an eight-channel I2C switch: slave interface and channel-select register.
`default_nettype none
module i2csw_ctrl
  import i2csw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap_bit0,
  input  wire logic       addr_strap_bit1,
  input  wire logic       addr_strap_bit2,
  output logic [7:0]      channel_enable,
  output logic [7:0]      channel_select_value
);
  import i2csw_pkg::*;

  typedef struct packed {
    logic          scl_prev;
    logic          sda_prev;
    i2csw_state_t  state;
    logic [3:0]    bit_cnt;
    logic [7:0]    shift;
    logic [7:0]    channel_select;
    logic [7:0]    pending;
    logic          pending_valid;
    logic [7:0]    active;
    logic          sda_drive_low;
  } i2csw_regs_t;

  i2csw_regs_t s_reg;
  i2csw_regs_t s_next;
  logic        scl_s;
  logic        sda_s;
  logic        srst_n;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic [6:0]  own_addr;
  logic        rst_meta_reg;
  logic        rst_sync_reg;

  // Reset asserts at once but is released on clk, so no flop sees its release near an edge.
  // reset release sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign srst_n = rst_sync_reg;

  // Bus lines are asynchronous to clk, so each passes two flops first.
  i2csw_sync u_sync_scl (
    .clk      (clk),
    .rst_n    (srst_n),
    .async_in (scl_in),
    .sync_out (scl_s)
  );
  i2csw_sync u_sync_sda (
    .clk      (clk),
    .rst_n    (srst_n),
    .async_in (sda_in),
    .sync_out (sda_s)
  );

  // oversampled edges
  // At 25 MHz a 400 kHz SCL gives over thirty samples per low or high phase.
  assign scl_rise = scl_s & ~s_reg.scl_prev;
  assign scl_fall = ~scl_s & s_reg.scl_prev;
  assign start_det = scl_s & s_reg.scl_prev & s_reg.sda_prev & ~sda_s;
  assign stop_det  = scl_s & s_reg.scl_prev & ~s_reg.sda_prev & sda_s;
  assign own_addr = {ADDR_FIXED_UPPER, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};

  always_comb begin
    s_next          = s_reg;
    s_next.scl_prev = scl_s;
    s_next.sda_prev = sda_s;
    if (scl_rise && s_reg.bit_cnt < BITS_PER_BYTE) begin
      s_next.shift   = {s_reg.shift[6:0], sda_s};
      s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
    end
    unique case (s_reg.state)
      I2CSW_IDLE: begin
        // Bits still shift in while idle, but a start clears the count before it is used.
        s_next.sda_drive_low = 1'b0;
      end
      I2CSW_ADDR: begin
        if (scl_fall && s_reg.bit_cnt == BITS_PER_BYTE) begin
          if (s_reg.shift[7:1] == own_addr) begin
            s_next.state         = I2CSW_AACK;
            s_next.sda_drive_low = 1'b1;
          end else begin
            // A foreign address leaves SDA alone, so another device on the bus can answer.
            // mismatch to idle
            s_next.state = I2CSW_IDLE;
          end
        end
      end
      I2CSW_AACK: begin
        if (scl_fall) begin
          s_next.bit_cnt = 4'h0;
          if (s_reg.shift[DIR_BIT_POS]) begin
            s_next.state         = I2CSW_RDATA;
            s_next.shift         = s_reg.channel_select;
            s_next.sda_drive_low = ~s_reg.channel_select[7];
          end else begin
            s_next.state         = I2CSW_WDATA;
            s_next.sda_drive_low = 1'b0;
          end
        end
      end
      I2CSW_WDATA: begin
        if (scl_fall && s_reg.bit_cnt == BITS_PER_BYTE) begin
          s_next.state         = I2CSW_WACK;
          s_next.sda_drive_low = 1'b1;
          s_next.channel_select = s_reg.shift;
          s_next.pending        = s_reg.shift;
          s_next.pending_valid  = 1'b1;
        end
      end
      I2CSW_WACK: begin
        if (scl_fall) begin
          s_next.state         = I2CSW_WDATA;
          s_next.bit_cnt       = 4'h0;
          s_next.sda_drive_low = 1'b0;
        end
      end
      I2CSW_RDATA: begin
        // Each read byte is loaded whole at its first bit, so the master never sees a torn value.
        if (scl_rise) begin
          s_next.shift   = {s_reg.shift[6:0], 1'b0};
          s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
        end
        if (scl_fall) begin
          if (s_reg.bit_cnt == BITS_PER_BYTE) begin
            s_next.state         = I2CSW_RACK;
            s_next.sda_drive_low = 1'b0;
          end else begin
            s_next.sda_drive_low = ~s_reg.shift[7];
          end
        end
      end
      I2CSW_RACK: begin
        if (scl_rise) begin
          s_next.bit_cnt = 4'h9;
          s_next.shift   = {7'h00, sda_s};
        end
        if (scl_fall) begin
          if (s_reg.shift[0]) begin
            s_next.state         = I2CSW_IDLE;
            s_next.sda_drive_low = 1'b0;
          end else begin
            s_next.state         = I2CSW_RDATA;
            s_next.bit_cnt       = 4'h0;
            s_next.shift         = s_reg.channel_select;
            s_next.sda_drive_low = ~s_reg.channel_select[7];
          end
        end
      end
      default: begin
        s_next.state         = I2CSW_IDLE;
        s_next.sda_drive_low = 1'b0;
      end
    endcase
    // Start and stop are tested last so that they override whatever the bus phase decided.
    // start restarts
    if (start_det) begin
      s_next.state         = I2CSW_ADDR;
      s_next.bit_cnt       = 4'h0;
      s_next.sda_drive_low = 1'b0;
    end
    if (stop_det) begin
      s_next.state         = I2CSW_IDLE;
      s_next.sda_drive_low = 1'b0;
      // A read-only transaction leaves pending_valid clear, so its stop keeps the channels as they are.
      // connect on stop
      if (s_reg.pending_valid) begin
        s_next.active        = s_reg.pending;
        s_next.pending_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      s_reg.scl_prev       <= 1'b1;
      s_reg.sda_prev       <= 1'b1;
      s_reg.state          <= I2CSW_IDLE;
      s_reg.bit_cnt        <= 4'h0;
      s_reg.shift          <= 8'h00;
      s_reg.channel_select <= CHAN_SEL_RESET;
      s_reg.pending        <= CHAN_SEL_RESET;
      s_reg.pending_valid  <= 1'b0;
      s_reg.active         <= CHAN_SEL_RESET;
      s_reg.sda_drive_low  <= 1'b0;
    end else begin
      s_reg.scl_prev       <= s_next.scl_prev;
      s_reg.sda_prev       <= s_next.sda_prev;
      s_reg.state          <= s_next.state;
      s_reg.bit_cnt        <= s_next.bit_cnt;
      s_reg.shift          <= s_next.shift;
      s_reg.channel_select <= s_next.channel_select;
      s_reg.pending        <= s_next.pending;
      s_reg.pending_valid  <= s_next.pending_valid;
      s_reg.active         <= s_next.active;
      s_reg.sda_drive_low  <= s_next.sda_drive_low;
    end
  end

  // Open drain: the device only ever pulls low.
  assign sda_out              = 1'b0;
  assign sda_oe               = s_reg.sda_drive_low;
  assign channel_enable       = s_reg.active;
  assign channel_select_value = s_reg.channel_select;

  // The checks below watch the registered state, one clock after the decision that they guard.
  // ack held to fall
  a_addr_ack_hold: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_AACK && !scl_fall) |=> sda_oe)
    else $error("Address ack not held low.");
  a_enable_on_stop: assert property (@(posedge clk) disable iff (!srst_n)
    (channel_enable != $past(channel_enable)) |-> $past(stop_det))
    else $error("Channel enable changed without stop.");
  a_stop_release: assert property (@(posedge clk) disable iff (!srst_n)
    stop_det |=> (!sda_oe && s_reg.state == I2CSW_IDLE))
    else $error("Stop did not release SDA.");
  a_start_addr: assert property (@(posedge clk) disable iff (!srst_n)
    start_det |=> (s_reg.state == I2CSW_ADDR && s_reg.bit_cnt == 4'h0))
    else $error("Start not followed by address phase.");
  a_read_ack_free: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_RACK) |-> !sda_oe)
    else $error("SDA driven during master ack.");
  a_write_store: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_WDATA && scl_fall && s_reg.bit_cnt == BITS_PER_BYTE && !stop_det && !start_det)
    |=> (channel_select_value == $past(s_reg.shift)))
    else $error("Written byte not stored.");
  // drive changes only with SCL low
  a_sda_change_low: assert property (@(posedge clk) disable iff (!srst_n)
    (sda_oe != $past(sda_oe) && !$past(start_det) && !$past(stop_det)) |-> !$past(scl_s))
    else $error("SDA drive changed while SCL high.");
  a_addr_mismatch: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_ADDR && scl_fall && s_reg.bit_cnt == BITS_PER_BYTE
     && s_reg.shift[7:1] != own_addr && !start_det && !stop_det) |=> s_reg.state == I2CSW_IDLE)
    else $error("Foreign address not ignored.");

  a_dir_read: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_AACK && scl_fall && s_reg.shift[DIR_BIT_POS] && !start_det && !stop_det)
    |=> (s_reg.state == I2CSW_RDATA && s_reg.shift == channel_select_value))
    else $error("Read direction not decoded.");

  a_dir_write: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_AACK && scl_fall && !s_reg.shift[DIR_BIT_POS] && !start_det && !stop_det)
    |=> (s_reg.state == I2CSW_WDATA && !sda_oe))
    else $error("Write direction not decoded.");

  a_data_ack_hold: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_WACK) |-> sda_oe)
    else $error("Data byte not acknowledged.");

  a_nack_release: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_RACK && scl_fall && s_reg.shift[0] && !start_det && !stop_det)
    |=> (s_reg.state == I2CSW_IDLE && !sda_oe))
    else $error("Read NACK did not release SDA.");

  a_read_repeat: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_RACK && scl_fall && !s_reg.shift[0] && !start_det && !stop_det)
    |=> (s_reg.state == I2CSW_RDATA && s_reg.shift == channel_select_value))
    else $error("Read ACK did not reload the selection.");

  a_write_next: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_WACK && scl_fall && !start_det && !stop_det)
    |=> (s_reg.state == I2CSW_WDATA && s_reg.bit_cnt == 4'h0))
    else $error("Write did not accept a further byte.");

  a_idle_release: assert property (@(posedge clk) disable iff (!srst_n)
    (s_reg.state == I2CSW_IDLE) |-> !sda_oe)
    else $error("SDA driven while idle.");

  a_reset_clear: assert property (@(posedge clk)
    !srst_n |-> (channel_enable == CHAN_SEL_RESET && channel_select_value == CHAN_SEL_RESET && !sda_oe))
    else $error("Reset did not clear the outputs.");
endmodule
`default_nettype wire

/* File: design/i2csw_pkg.sv */
// Package of constants and types for the eight-channel I2C switch control logic.
`default_nettype none
package i2csw_pkg;
  localparam int unsigned CLK_FREQ_HZ       = 25000000;
  localparam int unsigned FAST_MODE_HZ      = 400000;
  localparam int unsigned STD_MODE_HZ       = 100000;
  localparam int unsigned MIN_RESET_LOW_NS  = 6;
  localparam int unsigned CLK_PERIOD_NS     = 1000000000 / CLK_FREQ_HZ;
  // Least reset low width in clock cycles, rounded up, at least one.
  localparam int unsigned MIN_RESET_LOW_CYC =
    ((MIN_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((MIN_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned NUM_CHANNELS      = 8;
  localparam logic [3:0]  ADDR_FIXED_UPPER  = 4'hE;
  localparam logic [7:0]  CHAN_SEL_RESET    = 8'h00;
  localparam int unsigned DIR_BIT_POS       = 0;
  localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;

  typedef enum logic [2:0] {
    I2CSW_IDLE   = 3'h0,
    I2CSW_ADDR   = 3'h1,
    I2CSW_AACK   = 3'h3,
    I2CSW_WDATA  = 3'h2,
    I2CSW_WACK   = 3'h6,
    I2CSW_RDATA  = 3'h7,
    I2CSW_RACK   = 3'h5
  } i2csw_state_t;
endpackage
`default_nettype wire

/* File: design/i2csw_sync.sv */
// Two flip-flop synchroniser for one asynchronous input level.
`default_nettype none
module i2csw_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;
  // Both flops reset to one, the idle level of a pulled-up bus line.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: verification/i2csw_ctrl_tb_top.sv */
// Self-checking bench of the I2C switch control logic against an upstream master model.
`default_nettype none
module i2csw_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] strap;
    logic [6:0] addr;
    logic [7:0] data;
    logic       hit;
  } i2csw_row_t;
  logic       clk;
  logic       rst_n;
  logic [2:0] strap;
  logic       scl;
  logic       sda_low;
  logic       sda_wire;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] channel_enable;
  logic [7:0] channel_select_value;
  int         n_mismatch;
  int         samples_checked;
  logic [7:0] held;
  logic       ack;
  logic [7:0] rd;
  i2csw_row_t rows [4];
  // The bus line is low if either party pulls it; the pull-up gives high otherwise.
  assign sda_wire = (sda_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
  i2csw_ctrl i2csw_ctrl_inst (
    .clk                  (clk),
    .rst_n                (rst_n),
    .scl_in               (scl),
    .sda_in               (sda_wire),
    .sda_out              (sda_out),
    .sda_oe               (sda_oe),
    .addr_strap_bit0      (strap[0]),
    .addr_strap_bit1      (strap[1]),
    .addr_strap_bit2      (strap[2]),
    .channel_enable       (channel_enable),
    .channel_select_value (channel_select_value)
  );
  i2csw_master_model i2csw_master_model_inst (
    .scl      (scl),
    .sda_low  (sda_low),
    .sda_wire (sda_wire)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic results();
    $display("Checks made %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic wr_addr(input logic [6:0] a, input logic rnw, input logic ack_exp);
    i2csw_master_model_inst.start();
    i2csw_master_model_inst.write_byte({a, rnw}, ack);
    check({7'h00, ack}, {7'h00, ack_exp});
  endtask
  task automatic wr_data(input logic [7:0] d);
    i2csw_master_model_inst.write_byte(d, ack);
    check({7'h00, ack}, 8'h01);
  endtask
  task automatic rd_data(input logic give_ack, input logic [7:0] exp);
    i2csw_master_model_inst.read_byte(give_ack, rd);
    check(rd, exp);
  endtask
  task automatic stop_tx();
    i2csw_master_model_inst.stop();
    settle();
  endtask
  initial begin
    #2ms;
    n_mismatch++;
    $display("ERROR at %0t: watchdog ran out", $time);
    results();
  end
  initial begin
    rst_n = 1'b0;
    strap = 3'h0;
    n_mismatch = 0;
    samples_checked = 0;
    held = 8'h00;
    rows[0] = '{3'h0, 7'h70, 8'h01, 1'b1};
    rows[1] = '{3'h5, 7'h75, 8'hA5, 1'b1};
    rows[2] = '{3'h7, 7'h77, 8'h80, 1'b1};
    rows[3] = '{3'h3, 7'h70, 8'hFF, 1'b0};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check(channel_enable, 8'h00);
    check(channel_select_value, 8'h00);
    check({7'h00, sda_oe}, 8'h00);
    $display("Test reset done");
    foreach (rows[i]) begin
      @(posedge clk);
      strap <= rows[i].strap;
      settle();
      wr_addr(rows[i].addr, 1'b0, rows[i].hit);
      if (rows[i].hit) begin
        wr_data(rows[i].data);
        held = rows[i].data;
      end
      stop_tx();
      check(channel_enable, held);
      wr_addr(rows[i].addr, 1'b1, rows[i].hit);
      if (rows[i].hit) begin
        rd_data(1'b0, held);
      end
      stop_tx();
      $display("Test row %0d done", i);
    end
    @(posedge clk);
    strap <= 3'h2;
    settle();
    wr_addr(7'h72, 1'b0, 1'b1);
    wr_data(8'h3C);
    settle();
    check(channel_select_value, 8'h3C);
    check(channel_enable, held);
    wr_data(8'h5A);
    stop_tx();
    check(channel_enable, 8'h5A);
    $display("Test pending selection done");
    wr_addr(7'h72, 1'b1, 1'b1);
    rd_data(1'b1, 8'h5A);
    rd_data(1'b0, 8'h5A);
    settle();
    check({7'h00, sda_oe}, 8'h00);
    stop_tx();
    $display("Test read burst done");
    wr_addr(7'h72, 1'b0, 1'b1);
    wr_data(8'hC3);
    stop_tx();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check(channel_enable, 8'h00);
    check(channel_select_value, 8'h00);
    rst_n <= 1'b1;
    settle();
    wr_addr(7'h72, 1'b1, 1'b1);
    rd_data(1'b0, 8'h00);
    stop_tx();
    $display("Test reset mid-run done");
    results();
  end
endmodule
`default_nettype wire

/* File: verification/i2csw_master_model.sv */
// Behavioural upstream I2C master that drives SCL and pulls SDA low through open drain.
`default_nettype none
module i2csw_master_model (
  output var logic scl,
  output var logic sda_low,
  input  wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // A 320 ns SCL period gives four clocks per phase; the slave answers three clocks after an edge.
  // Lines move by non-blocking assignment, so the clock edge that they land on samples the old level.
  localparam int unsigned QUARTER_NS = 80;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    #QUARTER_NS;
    sda_low <= 1'b0;
    #QUARTER_NS;
    scl <= 1'b1;
    #QUARTER_NS;
    sda_low <= 1'b1;
    #QUARTER_NS;
    scl <= 1'b0;
  endtask
  // stop straight after the last acknowledge.
  task automatic stop();
    #QUARTER_NS;
    sda_low <= 1'b1;
    #QUARTER_NS;
    scl <= 1'b1;
    #QUARTER_NS;
    sda_low <= 1'b0;
    #QUARTER_NS;
  endtask
  // data changes only while SCL is low.
  task automatic bit_xfer(input logic b, output logic s);
    #QUARTER_NS;
    sda_low <= ~b;
    #QUARTER_NS;
    scl <= 1'b1;
    #QUARTER_NS;
    s = sda_wire;
    #QUARTER_NS;
    scl <= 1'b0;
  endtask
  // eight bits MSB first, then SDA released for the acknowledge.
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask
  // read a byte and acknowledge it or leave SDA high.
  task automatic read_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(~give_ack, s);
  endtask
endmodule
`default_nettype wire
